// ### src/em_pkg.sv
// Shared constants and types for the nonvolatile access controller.
// How it works
// - Ready interrupt needs enable bit and global enable.
// - Ready request is a level while idle.
// - No ready request while programming or self-programming.
// - Armed strobe write starts programming within four cycles.
// - Strobe write without arm is ignored.
// - Arm bit clears itself after four cycles.
// - Software sets arm before setting the strobe.
// - Software follows the fixed six-step write order.
// - No programming while flash self-program is busy.
// - Software keeps interrupts off during write sequence.
// - Hardware clears the strobe when programming ends.
// - Accepted write strobe stalls processor two cycles.
// - Read strobe loads data register at once.
// - Accepted read stalls processor four cycles.
// - Busy programming blocks reads and address changes.
// - Software polls strobe low before reading.
// - Program cycle lasts 26368 oscillator cycles.
// - Mode field selects erase-write, erase or write.
// - Mode field writes ignored while strobe set.
// - Address selects one of 1024 bytes.
// - Data register holds write byte and read result.
package em_pkg;

    // ****************************************************************
    // Register map of the device end
    // ****************************************************************
    localparam logic [1:0] OFF_CTRL    = 2'h0;
    localparam logic [1:0] OFF_DATA    = 2'h1;
    localparam logic [1:0] OFF_ADDR_LO = 2'h2;
    localparam logic [1:0] OFF_ADDR_HI = 2'h3;

    localparam int BIT_READ_STROBE  = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_ARM          = 2;
    localparam int BIT_READY_IE     = 3;
    localparam int BIT_MODE_LO      = 4;
    localparam int BIT_MODE_HI      = 5;

    localparam int          ADDR_W    = 10;
    localparam int          MEM_DEPTH = 1024;
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam logic [9:0]  ADDR_RST  = 10'h000;
    localparam logic [7:0]  ERASED    = 8'hff;

    // ****************************************************************
    // Timing counts in clock cycles and the program timer width
    // ****************************************************************
    localparam logic [2:0]  ARM_CYCLES   = 3'h4;
    localparam logic [2:0]  WRITE_STALL  = 3'h2;
    localparam logic [2:0]  READ_STALL   = 3'h4;
    localparam int          PROG_CYCLES  = 26368;
    localparam int          PROG_W       = 15;

    // ****************************************************************
    // Host register map
    // ****************************************************************
    localparam logic [3:0] H_FLAGS  = 4'h4;
    localparam logic [3:0] H_STATUS = 4'h5;
    localparam int BIT_GIE          = 0;
    localparam int BIT_SELF_PROG    = 1;
    localparam int BIT_STALL        = 0;
    localparam int BIT_IRQ          = 1;
    localparam int BIT_REFUSED      = 2;

    typedef enum logic [1:0] {
        MODE_ERASE_WRITE = 2'b00,
        MODE_ERASE_ONLY  = 2'b01,
        MODE_WRITE_ONLY  = 2'b10,
        MODE_RESERVED    = 2'b11
    } em_mode_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_PROG = 1'b1
    } em_state_e;

endpackage : em_pkg

// ### src/em_if.sv
// Internal register bus between the processor end and the device end.
`timescale 1ns/1ns
interface em_if;
    logic [1:0] io_addr;
    logic [7:0] io_wdata;
    logic       io_we;
    logic       global_irq_en;
    logic       self_prog_busy;
    logic [7:0] view_ctrl;
    logic [7:0] view_data;
    logic [9:0] view_addr;
    logic       ready_irq;
    logic       cpu_stall;

    modport dev (
        input  io_addr,
        input  io_wdata,
        input  io_we,
        input  global_irq_en,
        input  self_prog_busy,
        output view_ctrl,
        output view_data,
        output view_addr,
        output ready_irq,
        output cpu_stall
    );

    modport host (
        output io_addr,
        output io_wdata,
        output io_we,
        output global_irq_en,
        output self_prog_busy,
        input  view_ctrl,
        input  view_data,
        input  view_addr,
        input  ready_irq,
        input  cpu_stall
    );
endinterface : em_if

// ### src/em_dev.sv
// Device end: control register, program timer and byte store.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
module em_dev #(
    parameter int PROG_CYCLES = em_pkg::PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic clk_en,
    em_if.dev         bus,
    output logic      prog_active
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic                       write_strobe;
    logic                       master_write_arm;
    logic [2:0]                 arm_left;
    logic                       ready_irq_enable;
    em_pkg::em_mode_e           program_mode_sel;
    em_pkg::em_state_e          state;
    logic [em_pkg::PROG_W-1:0]  prog_left;
    logic [2:0]                 stall_left;
    logic [7:0]                 nv_data_reg;
    logic [9:0]                 nv_address_reg;
    logic [7:0]                 mem [em_pkg::MEM_DEPTH];
    logic                       wr_ctrl;
    logic                       start_prog;
    logic                       start_read;
    logic                       prog_done;

    assign wr_ctrl = bus.io_we && (bus.io_addr == em_pkg::OFF_CTRL);

    // The arm bit is sampled before this write lands, so arm and
    // strobe written together start a program cycle only if arm was already set.
    assign start_prog = wr_ctrl
                     && bus.io_wdata[em_pkg::BIT_WRITE_STROBE]
                     && master_write_arm
                     && (state == em_pkg::ST_IDLE)
                     && !bus.self_prog_busy;

    assign start_read = wr_ctrl
                     && bus.io_wdata[em_pkg::BIT_READ_STROBE]
                     && (state == em_pkg::ST_IDLE)
                     && !start_prog;

    assign prog_done = (state == em_pkg::ST_PROG)
                    && (prog_left == '0);

    // ****************************************************************
    // Program cycle state
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state        <= em_pkg::ST_IDLE;
            write_strobe <= 1'b0;
            prog_left    <= '0;
        end
        else if (clk_en)
        begin
            unique case (state)
                em_pkg::ST_IDLE:
                begin
                    if (start_prog)
                    begin
                        state        <= em_pkg::ST_PROG;
                        write_strobe <= 1'b1;
                        prog_left    <= em_pkg::PROG_W'(PROG_CYCLES - 1);
                    end
                end
                em_pkg::ST_PROG:
                begin
                    if (prog_done)
                    begin
                        state        <= em_pkg::ST_IDLE;
                        write_strobe <= 1'b0;
                    end
                    else
                    begin
                        prog_left <= prog_left - 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Arm bit with its four-cycle lifetime
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            master_write_arm <= 1'b0;
            arm_left         <= '0;
        end
        else if (clk_en)
        begin
            if (start_prog)
            begin
                master_write_arm <= 1'b0;
                arm_left         <= '0;
            end
            else if (wr_ctrl && bus.io_wdata[em_pkg::BIT_ARM])
            begin
                master_write_arm <= 1'b1;
                arm_left         <= em_pkg::ARM_CYCLES - 3'h1;
            end
            else if (master_write_arm && arm_left == '0)
            begin
                master_write_arm <= 1'b0;
            end
            else if (master_write_arm)
            begin
                arm_left <= arm_left - 3'h1;
            end
        end
    end

    // ****************************************************************
    // Control fields
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ready_irq_enable <= 1'b0;
            program_mode_sel <= em_pkg::MODE_ERASE_WRITE;
        end
        else if (clk_en && wr_ctrl)
        begin
            ready_irq_enable <= bus.io_wdata[em_pkg::BIT_READY_IE];
            if (!write_strobe)
            begin
                program_mode_sel <= em_pkg::em_mode_e'(
                    bus.io_wdata[em_pkg::BIT_MODE_HI:em_pkg::BIT_MODE_LO]);
            end
        end
    end

    // ****************************************************************
    // Address and data registers
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nv_address_reg <= em_pkg::ADDR_RST;
        end
        else if (clk_en && bus.io_we && state == em_pkg::ST_IDLE)
        begin
            if (bus.io_addr == em_pkg::OFF_ADDR_LO)
            begin
                nv_address_reg[7:0] <= bus.io_wdata;
            end
            else if (bus.io_addr == em_pkg::OFF_ADDR_HI)
            begin
                nv_address_reg[9:8] <= bus.io_wdata[1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nv_data_reg <= em_pkg::DATA_RST;
        end
        else if (clk_en)
        begin
            if (start_read)
            begin
                nv_data_reg <= mem[nv_address_reg];
            end
            else if (bus.io_we && bus.io_addr == em_pkg::OFF_DATA)
            begin
                nv_data_reg <= bus.io_wdata;
            end
        end
    end

    // ****************************************************************
    // Byte store
    // ****************************************************************
    // The cell changes only when the timer ends, so an aborted cycle
    // through reset leaves the old byte intact.
    always_ff @(posedge clock)
    begin
        if (clk_en && prog_done)
        begin
            unique case (program_mode_sel)
                em_pkg::MODE_ERASE_WRITE:
                    mem[nv_address_reg] <= nv_data_reg;
                em_pkg::MODE_ERASE_ONLY:
                    mem[nv_address_reg] <= em_pkg::ERASED;
                em_pkg::MODE_WRITE_ONLY:
                    mem[nv_address_reg] <= mem[nv_address_reg] & nv_data_reg;
                em_pkg::MODE_RESERVED:
                    mem[nv_address_reg] <= mem[nv_address_reg];
            endcase
        end
    end

    // ****************************************************************
    // Processor stall
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.cpu_stall <= 1'b0;
            stall_left    <= '0;
        end
        else if (clk_en)
        begin
            if (start_prog)
            begin
                bus.cpu_stall <= 1'b1;
                stall_left    <= em_pkg::WRITE_STALL - 3'h1;
            end
            else if (start_read)
            begin
                bus.cpu_stall <= 1'b1;
                stall_left    <= em_pkg::READ_STALL - 3'h1;
            end
            else if (stall_left != '0)
            begin
                stall_left <= stall_left - 3'h1;
            end
            else
            begin
                bus.cpu_stall <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Ready request and register views
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.ready_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            bus.ready_irq <= ready_irq_enable && bus.global_irq_en
                          && !write_strobe
                          && !bus.self_prog_busy;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.view_ctrl <= '0;
            bus.view_data <= em_pkg::DATA_RST;
            bus.view_addr <= em_pkg::ADDR_RST;
            prog_active   <= 1'b0;
        end
        else if (clk_en)
        begin
            bus.view_ctrl <= {2'b00, program_mode_sel, ready_irq_enable,
                              master_write_arm, write_strobe, 1'b0};
            bus.view_data <= nv_data_reg;
            bus.view_addr <= nv_address_reg;
            prog_active   <= write_strobe;
        end
    end

endmodule : em_dev

// ### src/em_host.sv
// Processor end: software port that drives the device register bus.
`timescale 1ns/1ns
module em_host (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    em_if.host              bus,
    input  wire logic [3:0] u_addr,
    input  wire logic [7:0] u_wdata,
    input  wire logic       u_we,
    input  wire logic       u_re,
    output logic      [7:0] u_rdata,
    output logic            cpu_irq
);

    logic refused;
    logic win;
    logic next_refused;

    assign win = (u_addr[3:2] == 2'b00);

    // Software that breaks the write order simply gets no write; the
    // device enforces it, this end forwards every device-window write except those made during a stall.
    // A set in the clearing cycle wins over the clear.
    assign next_refused = (u_we && win && bus.cpu_stall)
                       || (refused && !(u_we && u_addr == em_pkg::H_STATUS
                                        && u_wdata[em_pkg::BIT_REFUSED]));

    // ****************************************************************
    // Forwarding and own registers
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.io_we          <= 1'b0;
            bus.io_addr        <= em_pkg::OFF_CTRL;
            bus.io_wdata       <= '0;
            bus.global_irq_en  <= 1'b0;
            bus.self_prog_busy <= 1'b0;
            refused            <= 1'b0;
            cpu_irq            <= 1'b0;
        end
        else if (clk_en)
        begin
            bus.io_we    <= u_we && win && !bus.cpu_stall;
            bus.io_addr  <= u_addr[1:0];
            bus.io_wdata <= u_wdata;
            if (u_we && u_addr == em_pkg::H_FLAGS)
            begin
                bus.global_irq_en  <= u_wdata[em_pkg::BIT_GIE];
                bus.self_prog_busy <= u_wdata[em_pkg::BIT_SELF_PROG];
            end
            refused <= next_refused;
            cpu_irq <= bus.ready_irq;
        end
    end

    // ****************************************************************
    // Read data, valid only in the cycle after the read strobe
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            u_rdata <= '0;
        end
        else if (clk_en)
        begin
            u_rdata <= '0;
            if (u_re)
            begin
                unique case (u_addr)
                    4'h0:    u_rdata <= bus.view_ctrl;
                    4'h1:    u_rdata <= bus.view_data;
                    4'h2:    u_rdata <= bus.view_addr[7:0];
                    4'h3:    u_rdata <= {6'h00, bus.view_addr[9:8]};
                    em_pkg::H_FLAGS:
                        u_rdata <= {6'h00, bus.self_prog_busy,
                                    bus.global_irq_en};
                    em_pkg::H_STATUS:
                        u_rdata <= {5'h00, refused, bus.ready_irq,
                                    bus.cpu_stall};
                    default: u_rdata <= '0;
                endcase
            end
        end
    end

endmodule : em_host

// ### verification/em_properties.sv
// Concurrent checks on the register bus joining the two ends.
`timescale 1ns/1ns
module em_properties #(
    parameter int PROG_CYCLES = em_pkg::PROG_CYCLES
) (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_we,
    input wire logic       global_irq_en,
    input wire logic       self_prog_busy,
    input wire logic [7:0] view_ctrl,
    input wire logic [7:0] view_data,
    input wire logic [9:0] view_addr,
    input wire logic       ready_irq,
    input wire logic       cpu_stall
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic [15:0] prog_count;
    logic        ctrl_we;

    assign ctrl_we = io_we && (io_addr == em_pkg::OFF_CTRL);

    // Counts the cycles the strobe has been seen high so far.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            prog_count <= 16'h0000;
        else if (view_ctrl[1])
            prog_count <= prog_count + 16'h0001;
        else
            prog_count <= 16'h0000;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_irq_needs_gie: assert property (
        ready_irq |-> global_irq_en || $past(global_irq_en))
        else $error("ready request without global enable");
    chk_irq_needs_en: assert property (
        ready_irq |-> view_ctrl[3] || $past(view_ctrl[3]))
        else $error("ready request without its enable bit");
    chk_no_irq_prog: assert property (
        view_ctrl[1] && $past(view_ctrl[1]) |-> !ready_irq)
        else $error("ready request during a program cycle");
    chk_no_irq_self: assert property (
        $past(self_prog_busy) |-> !ready_irq)
        else $error("ready request during self programming");
    chk_write_stall: assert property (
        $rose(view_ctrl[1]) |-> cpu_stall && $past(cpu_stall)
        ##1 !cpu_stall)
        else $error("write stall is not two cycles");
    chk_read_stall: assert property (
        ctrl_we && io_wdata[0] && !io_wdata[1] && !view_ctrl[1]
        && !cpu_stall |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall is not four cycles");
    chk_arm_expiry: assert property (
        ctrl_we && io_wdata[2] && !io_wdata[1] && !view_ctrl[1]
        ##1 !io_we [*5] |-> view_ctrl[2] ##1 !view_ctrl[2])
        else $error("arm bit does not last four cycles");
    chk_strobe_no_arm: assert property (
        ctrl_we && io_wdata[1] && !view_ctrl[2] && !view_ctrl[1]
        && !$past(io_we) |-> ##2 !view_ctrl[1])
        else $error("strobe accepted without arm");
    chk_self_lock: assert property (
        ctrl_we && io_wdata[1] && self_prog_busy && !view_ctrl[1]
        && !$past(io_we) |-> ##2 !view_ctrl[1])
        else $error("strobe accepted during self programming");
    chk_prog_time: assert property (
        $fell(view_ctrl[1]) |-> prog_count == 16'(PROG_CYCLES))
        else $error("program cycle length wrong");
    chk_prog_bound: assert property (
        view_ctrl[1] |-> prog_count < 16'(PROG_CYCLES))
        else $error("strobe not cleared in time");
    chk_addr_frozen: assert property (
        view_ctrl[1] && $past(view_ctrl[1]) |-> $stable(view_addr))
        else $error("address changed during a program cycle");
    chk_mode_frozen: assert property (
        view_ctrl[1] && $past(view_ctrl[1]) |-> $stable(view_ctrl[5:4]))
        else $error("mode changed while strobe set");
endmodule : em_properties

// ### verification/tb_eeprom_access_control.sv
// Self-checking bench joining the processor end and the device end.
`timescale 1ns/1ns
module tb_eeprom_access_control;
    // Short program time keeps each byte write to a few dozen cycles.
    localparam int PROG = 20;
    logic       clock   = 1'b0;
    logic       arst_n  = 1'b0;
    logic       clk_en  = 1'b1;
    logic [3:0] u_addr  = 4'h0;
    logic [7:0] u_wdata = 8'h00;
    logic       u_we    = 1'b0;
    logic       u_re    = 1'b0;
    logic [7:0] u_rdata;
    logic       cpu_irq;
    logic       prog_active;
    logic [7:0] rv;
    int         bad_count   = 0;
    int         check_count = 0;

    em_if bus ();
    em_dev #(.PROG_CYCLES(PROG)) em_dev_i (.clock(clock), .arst_n(arst_n),
        .clk_en(clk_en), .bus(bus), .prog_active(prog_active));
    em_host em_host_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .bus(bus), .u_addr(u_addr), .u_wdata(u_wdata), .u_we(u_we),
        .u_re(u_re), .u_rdata(u_rdata), .cpu_irq(cpu_irq));
    em_properties #(.PROG_CYCLES(PROG)) em_properties_i (.clock(clock),
        .arst_n(arst_n), .io_addr(bus.io_addr), .io_wdata(bus.io_wdata),
        .io_we(bus.io_we), .global_irq_en(bus.global_irq_en),
        .self_prog_busy(bus.self_prog_busy), .view_ctrl(bus.view_ctrl),
        .view_data(bus.view_data), .view_addr(bus.view_addr),
        .ready_irq(bus.ready_irq), .cpu_stall(bus.cpu_stall));

    always #50 clock = ~clock;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        u_addr  <= a;
        u_wdata <= d;
        u_we    <= 1'b1;
        @(posedge clock);
        u_we <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        u_addr <= a;
        u_re   <= 1'b1;
        @(posedge clock);
        u_re <= 1'b0;
        @(negedge clock);
        rv = u_rdata;
    endtask : rd

    // Ends between edges so that flags read afterwards have settled.
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : idle

    task automatic wait_idle();
        int n;
        n = 0;
        rd(4'h0);
        while (rv[1] !== 1'b0 && n < 200)
        begin
            rd(4'h0);
            n++;
        end
        if (rv[1] !== 1'b0)
        begin
            chk(rv & 8'h02, 8'h00);
            finish_test();
        end
    endtask : wait_idle

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(4'h0); chk(rv, 8'h00);
        rd(4'h1); chk(rv, 8'h00);
        rd(4'h2); chk(rv, 8'h00);
        rd(4'h3); chk(rv, 8'h00);
        rd(4'h5); chk(rv, 8'h00);
        rd(4'h9); chk(rv, 8'h00);
    endtask : t_reset

    task automatic t_refuse();
        wr(4'h0, 8'h02); idle(3); rd(4'h0);
        chk(rv & 8'h02, 8'h00);
        wr(4'h0, 8'h04); idle(1); rd(4'h0);
        chk(rv & 8'h04, 8'h04);
        idle(3); rd(4'h0);
        chk(rv & 8'h04, 8'h00);
        wr(4'h0, 8'h02); idle(3); rd(4'h0);
        chk(rv & 8'h02, 8'h00);
        wr(4'h4, 8'h03); wr(4'h0, 8'h0c); wr(4'h0, 8'h0a);
        idle(3); rd(4'h0);
        chk(rv & 8'h02, 8'h00);
        chk({7'h00, cpu_irq}, 8'h00);
        wr(4'h4, 8'h00);
    endtask : t_refuse

    task automatic t_irq();
        wr(4'h0, 8'h08); idle(5);
        chk({7'h00, cpu_irq}, 8'h00);
        wr(4'h4, 8'h01); idle(5);
        chk({7'h00, cpu_irq}, 8'h01);
        idle(10); rd(4'h5);
        chk({7'h00, cpu_irq}, 8'h01);
        chk(rv & 8'h02, 8'h02);
        wr(4'h0, 8'h00); idle(5);
        chk({7'h00, cpu_irq}, 8'h00);
    endtask : t_irq

    task automatic t_program(input logic [1:0] m, input logic [7:0] d,
                             input logic [7:0] exp);
        // Global interrupts stay off until the strobe has been taken.
        wr(4'h4, 8'h00);
        wr(4'h2, 8'hff); wr(4'h3, 8'h03); wr(4'h1, d);
        wr(4'h0, {2'b00, m, 4'hc});
        wr(4'h0, {2'b00, m, 4'ha});
        // The first write lands in the stall and is refused by the host;
        // the next two reach the device while it is programming.
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h09);
        wr(4'h2, 8'h00);
        wr(4'h4, 8'h01);
        rd(4'h0); chk(rv & 8'h02, 8'h02);
        chk({7'h00, cpu_irq}, 8'h00);
        rd(4'h1); chk(rv, d);
        rd(4'h5); chk(rv & 8'h04, 8'h04);
        wr(4'h5, 8'h04); rd(4'h5); chk(rv & 8'h04, 8'h00);
        wait_idle();
        idle(4); chk({7'h00, cpu_irq}, 8'h01);
        wr(4'h0, 8'h09); idle(6);
        rd(4'h1); chk(rv, exp);
        rd(4'h2); chk(rv, 8'hff);
    endtask : t_program

    task automatic t_modes();
        logic [7:0] din [4]  = '{8'h5a, 8'h00, 8'h0f, 8'h00};
        logic [7:0] dexp [4] = '{8'h5a, 8'hff, 8'h0f, 8'h0f};
        wr(4'h4, 8'h01);
        for (int m = 0; m < 4; m++)
            t_program(2'(m), din[m], dexp[m]);
    endtask : t_modes

    initial
    begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_refuse();
        t_irq();
        t_modes();
        finish_test();
    end
endmodule : tb_eeprom_access_control
